/* File: bench/csf_mem_model.sv */
`timescale 1ns/1ps
module csf_mem_model (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic mem_req_i,
  input wire logic mem_we_i,
  input wire logic [14:0] mem_addr_i,
  input wire logic [15:0] mem_wdata_i,
  input wire logic [3:0] lat_i,
  output logic mem_ack_o,
  output logic [15:0] mem_rdata_o
);
  logic [15:0] mem [0:32767];
  logic [3:0] cnt_reg;
  // Released read data is inverted so a stale word never looks valid.
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mem_ack_o <= 1'b0;
      mem_rdata_o <= 16'h0;
      cnt_reg <= 4'h0;
    end else if (mem_ack_o || !mem_req_i) begin
      mem_ack_o <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o;
      cnt_reg <= 4'h0;
    end else if (cnt_reg >= lat_i) begin
      mem_ack_o <= 1'b1;
      mem_rdata_o <= mem[mem_addr_i];
      if (mem_we_i) mem[mem_addr_i] <= mem_wdata_i;
    end else cnt_reg <= cnt_reg + 4'h1;
  end
endmodule : csf_mem_model

/* File: bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import csf_pkg::*;
  logic mclk_i = 1'b0, sys_rst_i = 1'b1, op_valid_i = 1'b0, carry_i = 1'b0;
  logic tbl_we_i = 1'b0, mem_ack_i, instr_valid_o, busy_o, mem_req_o;
  logic mem_we_o, acc_we_o, float_we_o, carry_we_o, carry_o, stack_fault_o;
  csf_op_t op_i = OP_NEXT;
  logic [14:0] ea_i = 15'h0, irq_vec_i = 15'h0, tbl_wdata_i = 15'h0;
  logic [14:0] pc_o, mem_addr_o, p;
  logic [15:0] acc0_i = 16'h0, acc1_i = 16'h0, acc2_i = 16'h0;
  logic [15:0] acc3_i = 16'h0, lo_i = 16'h0, hi_i = 16'h0, last_wb = 16'h0;
  logic [15:0] float_word_i = 16'h0, mem_rdata_i, instr_o, mem_wdata_o;
  logic [15:0] wb_data_o;
  logic [1:0] src_i = 2'h0, dst_i = 2'h1;
  logic [5:0] sel_i = 6'h0, tbl_idx_i = 6'h0;
  logic [3:0] bit_i = 4'h0, lat = 4'h0;
  logic [4:0] wb_idx_o, float_idx_o;
  int fails = 0, n_tests = 0, cyc = 0, n_flt = 0;
  csf_op_t op;
  csf_core i_dut (.mclk_i, .sys_rst_i, .op_valid_i, .op_i, .ea_i, .acc0_i,
    .acc1_i, .acc2_i, .acc3_i, .carry_i, .src_i, .dst_i, .sel_i, .bit_i,
    .lo_i, .hi_i, .irq_vec_i, .float_word_i, .tbl_we_i, .tbl_idx_i,
    .tbl_wdata_i, .mem_rdata_i, .mem_ack_i, .pc_o, .instr_o, .instr_valid_o,
    .busy_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .acc_we_o,
    .float_we_o, .carry_we_o, .carry_o, .wb_idx_o, .wb_data_o, .float_idx_o,
    .stack_fault_o);
  csf_mem_model i_mem (.mclk_i, .sys_rst_i, .mem_req_i(mem_req_o),
    .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
    .lat_i(lat), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));
  always #25 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    if (acc_we_o === 1'b1) last_wb <= wb_data_o;
    if (stack_fault_o === 1'b1) n_flt++;
    cyc++;
    if (cyc == 20000) begin
      fails++;
      complete_run();
    end
  end
  function automatic logic [14:0] nxt(logic [14:0] a, logic [14:0] n);
    return a + n;
  endfunction : nxt
  function automatic logic skp(csf_op_t o, logic [15:0] s, logic [15:0] d);
    if (o == OP_COMPARE_TO_LIMITS) begin
      return $signed(s) >= $signed(lo_i) && $signed(s) <= $signed(hi_i);
    end
    return o == OP_SKIP_GREATER ? $signed(s) > $signed(d)
                                : $signed(s) >= $signed(d);
  endfunction : skp
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic run_op(input csf_op_t o, input logic [14:0] ea);
    int k;
    @(posedge mclk_i);
    #1 op_i = o;
    ea_i = ea;
    op_valid_i = 1'b1;
    lat = 4'($urandom_range(3));
    @(posedge mclk_i);
    #1 op_valid_i = 1'b0;
    for (k = 0; k < 300 && busy_o !== 1'b0; k++) begin
      @(posedge mclk_i);
      #1;
    end
    chk(instr_o, i_mem.mem[pc_o]);
  endtask : run_op
  task automatic complete_run;
    $display("Checks %0d, errors %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  initial begin
    void'($urandom(32'h564b20e3));
    for (int i = 0; i < 32768; i++) i_mem.mem[i] = 16'(i * 7);
    repeat (5) @(posedge mclk_i);
    #1 sys_rst_i = 1'b0;
    repeat (10) @(posedge mclk_i);
    run_op(OP_JUMP, 15'h7ffe);
    chk({1'b0, pc_o}, 16'h7ffe);
    repeat (2) begin
      p = nxt(pc_o, 15'h1);
      run_op(OP_NEXT, 15'h0);
      chk({1'b0, pc_o}, {1'b0, p});
    end
    p = pc_o;
    run_op(OP_JUMP_TO_SUBROUTINE, 15'h1234);
    chk(last_wb, {1'b0, nxt(p, 15'h1)});
    chk({1'b0, pc_o}, 16'h1234);
    for (int i = 0; i < 24; i++) begin
      {acc0_i, acc1_i, acc2_i, acc3_i} = {$urandom, $urandom};
      {lo_i, hi_i, float_word_i} = {$urandom, 16'($urandom)};
      {carry_i, bit_i, sel_i} = 11'($urandom);
      if (i < 2) acc1_i = acc0_i;
      if (i == 2) {lo_i, hi_i} = {acc0_i, acc0_i};
      op = csf_op_t'(5'h03 + 5'(i % 3));
      p = nxt(pc_o, skp(op, acc0_i, acc1_i) ? 15'h2 : 15'h1);
      run_op(op, 15'($urandom));
      chk({1'b0, pc_o}, {1'b0, p});
    end
    p = pc_o;
    irq_vec_i = 15'($urandom);
    run_op(OP_INTERRUPT, 15'h0);
    chk(i_mem.mem[0], {1'b0, p});
    chk({1'b0, pc_o}, {1'b0, irq_vec_i});
    i_mem.mem[15'h20] = 16'h0100;
    i_mem.mem[15'h22] = 16'hffff;
    p = pc_o;
    run_op(OP_PUSH_RETURN_ADDRESS, 15'h0);
    chk(i_mem.mem[15'h101], {1'b0, nxt(p, 15'h2)});
    chk(i_mem.mem[15'h20], 16'h0101);
    run_op(OP_POP_AND_JUMP, 15'h0);
    chk({1'b0, pc_o}, {1'b0, nxt(p, 15'h2)});
    chk(i_mem.mem[15'h20], 16'h0100);
    i_mem.mem[15'h300] = 16'hffff;
    p = pc_o;
    run_op(OP_INCREMENT_SKIP_ZERO, 15'h300);
    chk(i_mem.mem[15'h300], 16'h0);
    chk({1'b0, pc_o}, {1'b0, nxt(p, 15'h2)});
    p = pc_o;
    run_op(OP_DECREMENT_SKIP_ZERO, 15'h300);
    chk(i_mem.mem[15'h300], 16'hffff);
    chk({1'b0, pc_o}, {1'b0, nxt(p, 15'h1)});
    bit_i = 4'h0;
    i_mem.mem[15'h301] = 16'h0;
    p = pc_o;
    run_op(OP_BIT_TEST_AND_SET_SKIP, 15'h301);
    chk(i_mem.mem[15'h301], 16'h8000);
    chk({1'b0, pc_o}, {1'b0, nxt(p, 15'h2)});
    {acc0_i, lo_i, hi_i} = {16'h0005, 16'h0000, 16'h0010};
    i_mem.mem[15'h505] = 16'h0777;
    run_op(OP_TABLE_DISPATCH, 15'h500);
    chk({1'b0, pc_o}, 16'h0777);
    acc3_i = 16'hc321;
    i_mem.mem[15'h21] = 16'h0abc;
    p = pc_o;
    run_op(OP_SUBROUTINE_SAVE, 15'h0);
    chk(i_mem.mem[15'h101], acc0_i);
    chk(i_mem.mem[15'h104], 16'h0abc);
    chk(i_mem.mem[15'h105], {carry_i, acc3_i[14:0]});
    chk(i_mem.mem[15'h21], 16'h0105);
    chk({1'b0, pc_o}, {1'b0, nxt(p, 15'h1)});
    run_op(OP_SUBROUTINE_RETURN, 15'h0);
    chk({1'b0, pc_o}, {1'b0, acc3_i[14:0]});
    chk({15'h0, carry_o}, {15'h0, carry_i});
    chk(i_mem.mem[15'h21], 16'h0abc);
    chk(i_mem.mem[15'h20], 16'h0100);
    chk(last_wb, acc0_i);
    sel_i = 6'h07;
    @(posedge mclk_i);
    #1 {tbl_we_i, tbl_idx_i, tbl_wdata_i} = {1'b1, 6'h27, 15'h2468};
    @(posedge mclk_i);
    #1 tbl_we_i = 1'b0;
    p = pc_o;
    run_op(OP_EXTENDED_CALL_UPPER, 15'h0);
    chk({1'b0, pc_o}, 16'h2468);
    chk(last_wb, {14'h0, dst_i});
    chk(i_mem.mem[15'h105], {carry_i, nxt(p, 15'h1)});
    i_mem.mem[15'h22] = 16'h0105;
    i_mem.mem[15'h23] = 16'h0400;
    p = pc_o;
    run_op(OP_PUSH_RETURN_ADDRESS, 15'h0);
    chk(16'(n_flt), 16'h0001);
    chk({1'b0, pc_o}, 16'h0400);
    chk(i_mem.mem[15'h22], 16'h8105);
    chk(i_mem.mem[15'h20], 16'h010b);
    chk(i_mem.mem[15'h10b], {carry_i, nxt(p, 15'h1)});
    complete_run();
  end
endmodule : testbench

/* File: core/csf_core.sv */
`timescale 1ns/1ps
`include "csf_defines.svh"
module csf_core import csf_pkg::*; #(
  parameter int TABLE_DEPTH = `CSF_DISPATCH_ENTRIES
) (
  input logic mclk_i,
  input logic sys_rst_i,
  input logic op_valid_i,
  input csf_op_t op_i,
  input logic [14:0] ea_i,
  input logic [15:0] acc0_i,
  input logic [15:0] acc1_i,
  input logic [15:0] acc2_i,
  input logic [15:0] acc3_i,
  input logic carry_i,
  input logic [1:0] src_i,
  input logic [1:0] dst_i,
  input logic [5:0] sel_i,
  input logic [3:0] bit_i,
  input logic [15:0] lo_i,
  input logic [15:0] hi_i,
  input logic [14:0] irq_vec_i,
  input logic [15:0] float_word_i,
  input logic tbl_we_i,
  input logic [5:0] tbl_idx_i,
  input logic [14:0] tbl_wdata_i,
  input logic [15:0] mem_rdata_i,
  input logic mem_ack_i,
  output logic [14:0] pc_o,
  output logic [15:0] instr_o,
  output logic instr_valid_o,
  output logic busy_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [14:0] mem_addr_o,
  output logic [15:0] mem_wdata_o,
  output logic acc_we_o,
  output logic float_we_o,
  output logic carry_we_o,
  output logic carry_o,
  output logic [4:0] wb_idx_o,
  output logic [15:0] wb_data_o,
  output logic [4:0] float_idx_o,
  output logic stack_fault_o
);
  csf_state_t state_reg;
  csf_op_t op_reg;
  logic [14:0] pc_reg, pc_ret_reg, xaddr_reg, maddr_reg;
  logic [15:0] sp_reg, fp_reg, sl_reg, sf_reg, spx_reg, xword_reg;
  logic [15:0] instr_reg, wb_data_reg, mwdata_reg;
  logic [4:0] idx_reg, cnt_reg, wb_idx_reg;
  logic [1:0] ctl_idx_reg, src_reg, dst_reg;
  logic [5:0] sel_reg;
  logic [3:0] bit_reg;
  logic mreq_reg, mwe_reg, skip_reg, carry_reg, acc_we_reg;
  logic float_we_reg, carry_we_reg, valid_reg, busy_reg, fault_reg;
  logic [15:0] acc [4];
  logic [14:0] tbl_data;

  assign acc[0] = acc0_i;
  assign acc[1] = acc1_i;
  assign acc[2] = acc2_i;
  assign acc[3] = acc3_i;

  function automatic logic [14:0] pc_add(input logic [14:0] pc,
                                         input logic [14:0] k);
    return pc + k;
  endfunction : pc_add

  function automatic logic is_push(input csf_op_t op);
    return op inside {OP_EXTENDED_CALL, OP_EXTENDED_CALL_UPPER,
                      OP_SUBROUTINE_SAVE, OP_FLOAT_STATE_PUSH,
                      OP_MULTI_ACC_PUSH, OP_PUSH_RETURN_ADDRESS,
                      OP_STACK_FAULT};
  endfunction : is_push

  function automatic logic [4:0] word_cnt(input csf_op_t op,
                                          input logic [1:0] span);
    case (op)
      OP_FLOAT_STATE_PUSH, OP_FLOAT_STATE_POP: return `CSF_FLOAT_WORDS;
      OP_MULTI_ACC_PUSH, OP_MULTI_ACC_POP: return {3'h0, span} + 5'h01;
      OP_PUSH_RETURN_ADDRESS, OP_POP_AND_JUMP: return 5'h01;
      OP_INTERRUPT_RESTORE: return `CSF_RESTORE_WORDS;
      default: return `CSF_BLOCK_WORDS;
    endcase
  endfunction : word_cnt

  // Return block order is AC0..AC3 then the carry/PC word on top; a save puts FP in the AC3 slot and carry/AC3 on top.
  function automatic logic [15:0] push_word(input csf_op_t op,
                                            input logic [4:0] idx);
    case (op)
      OP_SUBROUTINE_SAVE: begin
        case (idx)
          5'h00: return acc[0];
          5'h01: return acc[1];
          5'h02: return acc[2];
          5'h03: return fp_reg;
          default: return {carry_i, acc[3][14:0]};
        endcase
      end
      OP_MULTI_ACC_PUSH: return acc[src_reg + idx[1:0]];
      OP_PUSH_RETURN_ADDRESS: return {1'b0, pc_add(pc_reg, 15'h0002)};
      OP_FLOAT_STATE_PUSH: return float_word_i;
      default: return (idx < 5'h04) ? acc[idx[1:0]] : {carry_i, pc_ret_reg};
    endcase
  endfunction : push_word

  function automatic logic [4:0] pop_dst(input csf_op_t op,
                                         input logic [4:0] idx);
    case (op)
      OP_SUBROUTINE_RETURN: begin
        if (idx == 5'h00) return {D_PCC, 2'h0};
        if (idx == 5'h01) return {D_FP, 2'h0};
        return {D_ACC, 2'(5'h04 - idx)};
      end
      OP_BLOCK_POP: begin
        if (idx == 5'h00) return {D_PCC, 2'h0};
        return {D_ACC, 2'(5'h04 - idx)};
      end
      OP_INTERRUPT_RESTORE: begin
        case (idx)
          5'h00: return {D_NONE, 2'h3};
          5'h01: return {D_SL, 2'h0};
          5'h02: return {D_FP, 2'h0};
          5'h03: return {D_SP, 2'h0};
          5'h04: return {D_PCC, 2'h0};
          default: return {D_ACC, 2'(5'h08 - idx)};
        endcase
      end
      OP_POP_AND_JUMP: return {D_PC, 2'h0};
      OP_MULTI_ACC_POP: return {D_ACC, dst_reg - idx[1:0]};
      OP_FLOAT_STATE_POP: return {D_FLT, 2'h0};
      default: return {D_NONE, 2'h0};
    endcase
  endfunction : pop_dst

  wire logic push_op = is_push(op_reg);
  wire logic [15:0] sp_inc = sp_reg + 16'h0001;
  wire logic [15:0] sp_dec = sp_reg - 16'h0001;
  wire logic last_word = idx_reg == (cnt_reg - 5'h01);
  wire logic ovf_now = sp_inc > sl_reg;
  wire logic need_mem = state_reg inside {S_FETCH, S_RDX, S_WRX, S_LDCTL,
                                          S_XFER, S_STCTL};
  wire logic launch = need_mem && !mreq_reg;
  wire logic done_cyc = mreq_reg && mem_ack_i;
  wire logic ctl_last = ctl_idx_reg == 2'h3;
  wire logic [14:0] ctl_addr = `CSF_CTL_BASE + {13'h0000, ctl_idx_reg};
  wire logic [15:0] ctl_word = (ctl_idx_reg == 2'h0) ? sp_reg :
                               (ctl_idx_reg == 2'h1) ? fp_reg :
                               (ctl_idx_reg == 2'h2) ? sl_reg : sf_reg;
  logic [15:0] push_data;
  logic [4:0] pdst;
  // A process also wakes on the state that the two functions read besides
  // their arguments, so a push never writes a word that has gone stale.
  always_comb begin
    push_data = push_word(op_reg, idx_reg);
    pdst = pop_dst(op_reg, idx_reg);
  end
  wire csf_dst_t pdst_kind = csf_dst_t'(pdst[4:2]);
  wire logic [14:0] xfer_addr = push_op ? sp_inc[14:0] : sp_reg[14:0];
  wire logic [14:0] cyc_addr = (state_reg == S_FETCH) ? pc_reg :
                               (state_reg == S_XFER) ? xfer_addr :
                               (state_reg inside {S_LDCTL, S_STCTL}) ?
                               ctl_addr : xaddr_reg;
  wire logic cyc_we = (state_reg inside {S_WRX, S_STCTL}) ||
                      (state_reg == S_XFER && push_op);
  wire logic [15:0] cyc_wdata = (state_reg == S_XFER) ? push_data :
                                (state_reg == S_STCTL) ? ctl_word :
                                xword_reg;
  wire logic [15:0] rd_dec = mem_rdata_i - 16'h0001;
  wire logic [15:0] rd_inc = mem_rdata_i + 16'h0001;
  // Bit 0 is the most significant bit of a word.
  wire logic [15:0] bit_mask = 16'h8000 >> bit_i;
  wire logic [15:0] bit_mask_q = 16'h8000 >> bit_reg;
  wire logic signed [15:0] val_s = $signed(acc[src_i]);
  wire logic cmp_ge = val_s >= $signed(acc[dst_i]);
  wire logic cmp_gt = val_s > $signed(acc[dst_i]);
  wire logic in_range = val_s >= $signed(lo_i) && val_s <= $signed(hi_i);
  wire logic ext_op = op_reg inside {OP_EXTENDED_CALL, OP_EXTENDED_CALL_UPPER};
  wire logic tbl_rd = state_reg == S_STCTL && done_cyc && ctl_last && ext_op;
  wire logic [5:0] tbl_ridx = (op_reg == OP_EXTENDED_CALL_UPPER) ?
                              {`CSF_UPPER_BASE, sel_reg[3:0]} : sel_reg;
  wire logic [14:0] pc_one = pc_add(pc_reg, 15'h0001);
  wire logic [14:0] pc_two = pc_add(pc_reg, 15'h0002);

  csf_dispatch_table #(.DEPTH(TABLE_DEPTH), .AW(6), .DW(15)) u_table (
    .clk_i(mclk_i),
    .rst_i(sys_rst_i),
    .we_i(tbl_we_i),
    .waddr_i(tbl_idx_i),
    .wdata_i(tbl_wdata_i),
    .rd_i(tbl_rd),
    .raddr_i(tbl_ridx),
    .rdata_o(tbl_data)
  );

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= S_FETCH;
      op_reg <= OP_NEXT;
      pc_reg <= `CSF_RESET_PC;
      {pc_ret_reg, xaddr_reg, maddr_reg} <= '0;
      {sp_reg, fp_reg, sl_reg, sf_reg, spx_reg, xword_reg} <= '0;
      {instr_reg, wb_data_reg, mwdata_reg} <= '0;
      {idx_reg, cnt_reg, wb_idx_reg} <= '0;
      {ctl_idx_reg, src_reg, dst_reg, sel_reg, bit_reg} <= '0;
      {mreq_reg, mwe_reg, skip_reg, carry_reg, acc_we_reg} <= '0;
      {float_we_reg, carry_we_reg, valid_reg, fault_reg} <= '0;
      busy_reg <= 1'b1;
    end else begin
      acc_we_reg <= 1'b0;
      float_we_reg <= 1'b0;
      carry_we_reg <= 1'b0;
      valid_reg <= 1'b0;
      fault_reg <= 1'b0;
      if (launch) begin
        mreq_reg <= 1'b1;
        mwe_reg <= cyc_we;
        maddr_reg <= cyc_addr;
        mwdata_reg <= cyc_wdata;
      end else if (done_cyc) begin
        mreq_reg <= 1'b0;
        mwe_reg <= 1'b0;
      end
      unique case (state_reg)
        S_FETCH: if (done_cyc) begin
          instr_reg <= mem_rdata_i;
          valid_reg <= 1'b1;
          busy_reg <= 1'b0;
          state_reg <= S_IDLE;
        end
        S_IDLE: if (op_valid_i) begin
          busy_reg <= 1'b1;
          op_reg <= op_i;
          {src_reg, dst_reg, sel_reg, bit_reg} <= {src_i, dst_i, sel_i, bit_i};
          pc_ret_reg <= pc_one;
          xaddr_reg <= ea_i;
          idx_reg <= 5'h00;
          ctl_idx_reg <= 2'h0;
          cnt_reg <= word_cnt(op_i, dst_i - src_i);
          state_reg <= S_FETCH;
          case (op_i)
            OP_NEXT: pc_reg <= pc_one;
            OP_JUMP: pc_reg <= ea_i;
            OP_JUMP_TO_SUBROUTINE: begin
              acc_we_reg <= 1'b1;
              wb_idx_reg <= 5'h03;
              wb_data_reg <= {1'b0, pc_one};
              pc_reg <= ea_i;
            end
            // Skips add two regardless of the length of what follows.
            OP_SKIP_GREATER_EQUAL: pc_reg <= cmp_ge ? pc_two : pc_one;
            OP_SKIP_GREATER: pc_reg <= cmp_gt ? pc_two : pc_one;
            OP_COMPARE_TO_LIMITS: pc_reg <= in_range ? pc_two : pc_one;
            OP_TABLE_DISPATCH: begin
              if (!in_range) begin
                pc_reg <= pc_two;
              end else begin
                xaddr_reg <= pc_add(ea_i, acc[src_i][14:0]);
                state_reg <= S_RDX;
              end
            end
            OP_DECREMENT_SKIP_ZERO, OP_INCREMENT_SKIP_ZERO,
            OP_BIT_TEST_AND_SET_SKIP: state_reg <= S_RDX;
            OP_INTERRUPT: begin
              xaddr_reg <= `CSF_IRQ_SAVE_LOC;
              xword_reg <= {1'b0, pc_reg};
              state_reg <= S_WRX;
            end
            default: state_reg <= S_LDCTL;
          endcase
        end
        S_RDX: if (done_cyc) begin
          state_reg <= S_WRX;
          case (op_reg)
            OP_DECREMENT_SKIP_ZERO: begin
              xword_reg <= rd_dec;
              skip_reg <= rd_dec == 16'h0000;
            end
            OP_INCREMENT_SKIP_ZERO: begin
              xword_reg <= rd_inc;
              skip_reg <= rd_inc == 16'h0000;
            end
            OP_BIT_TEST_AND_SET_SKIP: begin
              xword_reg <= mem_rdata_i | bit_mask_q;
              skip_reg <= (mem_rdata_i & bit_mask_q) == 16'h0000;
            end
            default: begin
              pc_reg <= mem_rdata_i[14:0];
              state_reg <= S_FETCH;
            end
          endcase
        end
        S_WRX: if (done_cyc) begin
          state_reg <= S_FETCH;
          if (op_reg == OP_INTERRUPT) begin
            pc_reg <= irq_vec_i;
          end else begin
            pc_reg <= skip_reg ? pc_two : pc_one;
          end
        end
        S_LDCTL: if (done_cyc) begin
          case (ctl_idx_reg)
            2'h0: sp_reg <= mem_rdata_i;
            2'h1: fp_reg <= mem_rdata_i;
            2'h2: sl_reg <= mem_rdata_i;
            default: sf_reg <= mem_rdata_i;
          endcase
          ctl_idx_reg <= ctl_idx_reg + 2'h1;
          if (ctl_last) begin
            state_reg <= S_XFER;
          end
        end
        S_XFER: if (done_cyc) begin
          idx_reg <= idx_reg + 5'h01;
          if (push_op) begin
            sp_reg <= sp_inc;
          end else begin
            sp_reg <= sp_dec;
            wb_data_reg <= mem_rdata_i;
            wb_idx_reg <= {3'h0, pdst[1:0]};
            case (pdst_kind)
              D_ACC: acc_we_reg <= 1'b1;
              D_PCC: begin
                carry_we_reg <= 1'b1;
                carry_reg <= mem_rdata_i[15];
                pc_reg <= mem_rdata_i[14:0];
              end
              D_PC: pc_reg <= mem_rdata_i[14:0];
              D_FP: fp_reg <= mem_rdata_i;
              D_SP: spx_reg <= mem_rdata_i;
              D_SL: sl_reg <= mem_rdata_i;
              D_FLT: begin
                float_we_reg <= 1'b1;
                wb_idx_reg <= `CSF_FLOAT_WORDS - 5'h01 - idx_reg;
              end
              default: if (pdst[1:0] == 2'h3) sf_reg <= mem_rdata_i;
            endcase
          end
          if (last_word) begin
            state_reg <= S_STCTL;
            ctl_idx_reg <= 2'h0;
            if (op_reg == OP_INTERRUPT_RESTORE) begin
              sp_reg <= spx_reg;
            end
            if (op_reg == OP_SUBROUTINE_SAVE) begin
              fp_reg <= sp_inc;
            end
            // Bit 15 tweaks keep the fault block from faulting again.
            if (push_op && op_reg != OP_STACK_FAULT && ovf_now) begin
              sp_reg <= {1'b0, sp_inc[14:0]};
              sl_reg <= {1'b1, sl_reg[14:0]};
              op_reg <= OP_STACK_FAULT;
              idx_reg <= 5'h00;
              cnt_reg <= `CSF_BLOCK_WORDS;
              fault_reg <= 1'b1;
              state_reg <= S_XFER;
            end
          end
        end
        S_STCTL: if (done_cyc) begin
          ctl_idx_reg <= ctl_idx_reg + 2'h1;
          if (ctl_last) begin
            state_reg <= S_FETCH;
            if (op_reg == OP_STACK_FAULT) begin
              pc_reg <= sf_reg[14:0];
            end else if (ext_op) begin
              acc_we_reg <= 1'b1;
              wb_idx_reg <= 5'h02;
              wb_data_reg <= {14'h0000, src_reg};
              state_reg <= S_TBL;
            end else if (!(op_reg inside {OP_SUBROUTINE_RETURN, OP_BLOCK_POP,
                         OP_INTERRUPT_RESTORE, OP_POP_AND_JUMP})) begin
              pc_reg <= pc_ret_reg;
            end
          end
        end
        S_TBL: begin
          acc_we_reg <= 1'b1;
          wb_idx_reg <= 5'h03;
          wb_data_reg <= {14'h0000, dst_reg};
          pc_reg <= tbl_data;
          state_reg <= S_FETCH;
        end
      endcase
    end
  end

  assign pc_o = pc_reg;
  assign instr_o = instr_reg;
  assign instr_valid_o = valid_reg;
  assign busy_o = busy_reg;
  assign mem_req_o = mreq_reg;
  assign mem_we_o = mwe_reg;
  assign mem_addr_o = maddr_reg;
  assign mem_wdata_o = mwdata_reg;
  assign acc_we_o = acc_we_reg;
  assign float_we_o = float_we_reg;
  assign carry_we_o = carry_we_reg;
  assign carry_o = carry_reg;
  assign wb_idx_o = wb_idx_reg;
  assign wb_data_o = wb_data_reg;
  assign float_idx_o = idx_reg;
  assign stack_fault_o = fault_reg;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  fetch_address_a: assert property (
    state_reg == S_FETCH && $rose(mreq_reg) |-> maddr_reg == pc_reg && !mwe_reg)
    else $error("fetch not at program counter");
  seq_advance_a: assert property (
    state_reg == S_IDLE && op_valid_i && op_i == OP_NEXT
    |=> pc_reg == $past(pc_reg) + 15'h0001)
    else $error("sequential advance wrong");
  skip_two_a: assert property (
    state_reg == S_IDLE && op_valid_i && op_i == OP_SKIP_GREATER && cmp_gt
    |=> pc_reg == $past(pc_reg) + 15'h0002)
    else $error("taken skip did not add two");
  irq_save_a: assert property (
    state_reg == S_WRX && op_reg == OP_INTERRUPT && $rose(mreq_reg)
    |-> maddr_reg == 15'h0000 && mwe_reg)
    else $error("interrupt return not written to zero");
  push_pre_inc_a: assert property (
    state_reg == S_XFER && push_op && $rose(mreq_reg)
    |-> mwe_reg && maddr_reg == sp_reg[14:0] + 15'h0001)
    else $error("push address not pointer plus one");
  ctl_loc_a: assert property (
    state_reg == S_LDCTL && $rose(mreq_reg)
    |-> maddr_reg == 15'h0020 + {13'h0000, ctl_idx_reg})
    else $error("stack control location wrong");
  fault_bits_a: assert property (
    stack_fault_o |-> !sp_reg[15] && sl_reg[15] && cnt_reg == 5'h05
    && state_reg == S_XFER)
    else $error("overflow entry state wrong");
  jsr_link_a: assert property (
    state_reg == S_IDLE && op_valid_i && op_i == OP_JUMP_TO_SUBROUTINE
    |=> acc_we_o && wb_idx_o == 5'h03 && wb_data_o[14:0] == $past(pc_one)
    && pc_reg == $past(ea_i))
    else $error("subroutine link wrong");
  upper_index_a: assert property (
    tbl_rd && op_reg == OP_EXTENDED_CALL_UPPER |-> tbl_ridx[5:4] == 2'h2)
    else $error("upper entry not offset by 32");
  float_cnt_a: assert property (
    state_reg == S_LDCTL && op_reg == OP_FLOAT_STATE_POP |-> cnt_reg == 5'h12)
    else $error("float state count wrong");

  fault_seen_c: cover property (stack_fault_o);
  dispatch_seen_c: cover property (state_reg == S_TBL);
  restore_seen_c: cover property (
    state_reg == S_XFER && op_reg == OP_INTERRUPT_RESTORE && last_word);
endmodule : csf_core

/* File: core/csf_defines.svh */
`ifndef CSF_DEFINES_SVH
`define CSF_DEFINES_SVH
`define CSF_RESET_PC 15'h0000
`define CSF_IRQ_SAVE_LOC 15'h0000
`define CSF_CTL_BASE 15'h0020
`define CSF_DISPATCH_ENTRIES 48
`define CSF_UPPER_BASE 2'h2
`define CSF_BLOCK_WORDS 5'h05
`define CSF_RESTORE_WORDS 5'h09
`define CSF_FLOAT_WORDS 5'h12
`endif

/* File: core/csf_dispatch_table.sv */
`timescale 1ns/1ps
module csf_dispatch_table #(
  parameter int DEPTH = 48,
  parameter int AW = 6,
  parameter int DW = 15
) (
  input logic clk_i,
  input logic rst_i,
  input logic we_i,
  input logic [AW-1:0] waddr_i,
  input logic [DW-1:0] wdata_i,
  input logic rd_i,
  input logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [DEPTH];
  logic [DW-1:0] rdata_reg;
  // Entries beyond the table depth read as zero rather than aliasing.
  wire logic rd_ok = int'(raddr_i) < DEPTH;
  always_ff @(posedge clk_i) begin
    if (we_i && int'(waddr_i) < DEPTH) begin
      mem[waddr_i] <= wdata_i;
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg <= '0;
    end else if (rd_i) begin
      rdata_reg <= rd_ok ? mem[raddr_i] : '0;
    end
  end
  assign rdata_o = rdata_reg;
endmodule : csf_dispatch_table

/* File: core/csf_pkg.sv */
package csf_pkg;
  typedef enum logic [4:0] {
    OP_NEXT = 5'h00, OP_JUMP = 5'h01, OP_JUMP_TO_SUBROUTINE = 5'h02,
    OP_SKIP_GREATER_EQUAL = 5'h03, OP_SKIP_GREATER = 5'h04,
    OP_COMPARE_TO_LIMITS = 5'h05, OP_TABLE_DISPATCH = 5'h06,
    OP_DECREMENT_SKIP_ZERO = 5'h07, OP_INCREMENT_SKIP_ZERO = 5'h08,
    OP_BIT_TEST_AND_SET_SKIP = 5'h09, OP_INTERRUPT = 5'h0a,
    OP_EXTENDED_CALL = 5'h0b, OP_EXTENDED_CALL_UPPER = 5'h0c,
    OP_SUBROUTINE_SAVE = 5'h0d, OP_SUBROUTINE_RETURN = 5'h0e,
    OP_FLOAT_STATE_PUSH = 5'h0f, OP_FLOAT_STATE_POP = 5'h10,
    OP_MULTI_ACC_PUSH = 5'h11, OP_MULTI_ACC_POP = 5'h12,
    OP_BLOCK_POP = 5'h13, OP_PUSH_RETURN_ADDRESS = 5'h14,
    OP_POP_AND_JUMP = 5'h15, OP_INTERRUPT_RESTORE = 5'h16,
    OP_STACK_FAULT = 5'h17
  } csf_op_t;
  typedef enum logic [2:0] {
    S_FETCH = 3'h0, S_IDLE = 3'h1, S_RDX = 3'h2, S_WRX = 3'h3,
    S_LDCTL = 3'h4, S_XFER = 3'h5, S_STCTL = 3'h6, S_TBL = 3'h7
  } csf_state_t;
  typedef enum logic [2:0] {
    D_NONE = 3'h0, D_ACC = 3'h1, D_PCC = 3'h2, D_PC = 3'h3,
    D_FP = 3'h4, D_SP = 3'h5, D_SL = 3'h6, D_FLT = 3'h7
  } csf_dst_t;
endpackage : csf_pkg
